// ===== rtl/porac_defs.svh
// Function
// - pull-down on general input zero follows its control bit.
// - regulator B power-good route: 00 none, 01 output 2, 10 output 3.
// - regulator A power-good route uses the same encoding as regulator B.
// - regulator B ready route: 00 none, 01 output 2, 10 output 3.
// - regulator A ready route uses the same encoding as regulator B.
// - mode bit 7: 0 companion operation, 1 independent operation.
// - oscillator trim raises frequency by code times 180 kHz.
// - alternate register bits 7:4 give the secondary address upper nibble.
// - secondary low nibble: 0/1 write/read pages 0-1, 2/3 pages 2-3.
// - upper nibble 0000 is unprogrammed; hardware default address used.
// - select field picks pin: 00 none, 01 input 0, 10 input 1, 11 input 4.
// - secondary address acts only when a select pin is configured.
`ifndef PORAC_DEFS_SVH
`define PORAC_DEFS_SVH

// ==========================================================
// register offsets
`define PORAC_OFS_PULLDOWN 9'h145
`define PORAC_OFS_ROUTING 9'h146
`define PORAC_OFS_MODE 9'h147
`define PORAC_OFS_ALTADDR 9'h148

// ==========================================================
// field positions
`define PORAC_PD_BIT 0
`define PORAC_PGB_LSB 6
`define PORAC_PGA_LSB 4
`define PORAC_RDYB_LSB 2
`define PORAC_RDYA_LSB 0
`define PORAC_INDEP_BIT 7
`define PORAC_TRIM_LSB 0
`define PORAC_UPPER_LSB 4
`define PORAC_SEL_LSB 0

// ==========================================================
// reset values
`define PORAC_RST_PULLDOWN 1'b0
`define PORAC_RST_ROUTING 8'h00
`define PORAC_RST_MODE 8'h00
`define PORAC_RST_UPPER 4'h0
`define PORAC_RST_SEL 2'h0

// ==========================================================
// timing and scale
`define PORAC_OSC_STEP_KHZ 11'h0b4

`endif

// ===== rtl/porac_pkg.sv
package porac_pkg;
    // output routing code
    typedef enum logic [1:0]
    {
        PORAC_ROUTE_NONE = 2'h0,
        PORAC_ROUTE_OUT2 = 2'h1,
        PORAC_ROUTE_OUT3 = 2'h2,
        PORAC_ROUTE_RSVD = 2'h3
    } porac_route_e;

    // address select pin code
    typedef enum logic [1:0]
    {
        PORAC_SEL_NONE = 2'h0,
        PORAC_SEL_IN0 = 2'h1,
        PORAC_SEL_IN1 = 2'h2,
        PORAC_SEL_IN4 = 2'h3
    } porac_sel_e;

    typedef logic [7:0] porac_byte_t;
endpackage

// ===== rtl/porac_top.sv
`timescale 1ns/1ps
`include "porac_defs.svh"

module porac_top
#(
    parameter logic [7:0] PRIMARY_ADDRESS = 8'hc0
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [8:0] reg_addr,
    input wire porac_pkg::porac_byte_t reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic reg_a_power_good,
    input wire logic reg_b_power_good,
    input wire logic reg_a_ready,
    input wire logic reg_b_ready,
    input wire logic general_input_0,
    input wire logic general_input_1,
    input wire logic general_input_4,
    input wire logic [7:0] bus_addr_byte,
    output logic general_output_2,
    output logic general_output_3,
    output logic input_zero_pulldown_en,
    output logic independent_operation,
    output logic [2:0] oscillator_trim,
    output logic [10:0] oscillator_trim_khz,
    output logic [7:0] active_base_address,
    output logic addr_hit,
    output logic addr_is_read,
    output logic addr_page_high
);
    import porac_pkg::*;

    // ==========================================================
    // reset release
    logic rst_meta_n;
    logic rst_n;

    // async assert, two-flop release
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ==========================================================
    // register file
    logic cfg_pd;
    logic [7:0] cfg_route;
    logic [7:0] cfg_mode;
    logic [3:0] cfg_upper;
    logic [1:0] cfg_sel;
    logic next_cfg_pd;
    logic [7:0] next_cfg_route;
    logic [7:0] next_cfg_mode;
    logic [3:0] next_cfg_upper;
    logic [1:0] next_cfg_sel;
    logic [7:0] next_reg_rdata;
    logic next_reg_rd_valid;

    // writes store fields; reads answer one cycle later, unmapped as zero
    always_comb
    begin
        next_cfg_pd = cfg_pd;
        next_cfg_route = cfg_route;
        next_cfg_mode = cfg_mode;
        next_cfg_upper = cfg_upper;
        next_cfg_sel = cfg_sel;
        next_reg_rdata = 8'h00;
        next_reg_rd_valid = reg_rd_en;
        if (reg_wr_en)
        begin
            case (reg_addr)
                `PORAC_OFS_PULLDOWN: next_cfg_pd = reg_wdata[`PORAC_PD_BIT];
                `PORAC_OFS_ROUTING: next_cfg_route = reg_wdata;
                `PORAC_OFS_MODE: next_cfg_mode = reg_wdata;
                `PORAC_OFS_ALTADDR:
                begin
                    next_cfg_upper = reg_wdata[`PORAC_UPPER_LSB +: 4];
                    next_cfg_sel = reg_wdata[`PORAC_SEL_LSB +: 2];
                end
                default: next_cfg_pd = cfg_pd;
            endcase
        end
        if (reg_rd_en)
        begin
            case (reg_addr)
                `PORAC_OFS_PULLDOWN: next_reg_rdata = {7'h00, cfg_pd};
                `PORAC_OFS_ROUTING: next_reg_rdata = cfg_route;
                `PORAC_OFS_MODE: next_reg_rdata = cfg_mode;
                // bits 3:2 are read-only reserved and read zero
                `PORAC_OFS_ALTADDR: next_reg_rdata = {cfg_upper, 2'h0, cfg_sel};
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_pd <= `PORAC_RST_PULLDOWN;
            cfg_route <= `PORAC_RST_ROUTING;
            cfg_mode <= `PORAC_RST_MODE;
            cfg_upper <= `PORAC_RST_UPPER;
            cfg_sel <= `PORAC_RST_SEL;
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            cfg_pd <= next_cfg_pd;
            cfg_route <= next_cfg_route;
            cfg_mode <= next_cfg_mode;
            cfg_upper <= next_cfg_upper;
            cfg_sel <= next_cfg_sel;
            reg_rdata <= next_reg_rdata;
            reg_rd_valid <= next_reg_rd_valid;
        end
    end

    // ==========================================================
    // pin synchronisers
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_filt;
    logic [2:0] next_pin_filt;

    // a change counts only once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            next_pin_filt[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i]
                                                        : pin_filt[i];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
            pin_filt <= 3'h0;
        end
        else
        begin
            pin_s1 <= {general_input_4, general_input_1, general_input_0};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_filt <= next_pin_filt;
        end
    end

    // ==========================================================
    // output routing and addressing
    logic next_out2;
    logic next_out3;
    logic next_pd;
    logic next_indep;
    logic [2:0] next_trim;
    logic [10:0] next_trim_khz;
    logic [7:0] next_base;
    logic next_hit;
    logic next_is_read;
    logic next_page_high;
    porac_route_e route_code [4];
    logic [3:0] route_sig;
    logic sel_pin;
    logic use_secondary;

    // indications OR together when several share an output
    always_comb
    begin
        route_code[0] = porac_route_e'(cfg_route[`PORAC_PGB_LSB +: 2]);
        route_code[1] = porac_route_e'(cfg_route[`PORAC_PGA_LSB +: 2]);
        route_code[2] = porac_route_e'(cfg_route[`PORAC_RDYB_LSB +: 2]);
        route_code[3] = porac_route_e'(cfg_route[`PORAC_RDYA_LSB +: 2]);
        route_sig = {reg_a_ready, reg_b_ready, reg_a_power_good,
                     reg_b_power_good};
        next_out2 = 1'b0;
        next_out3 = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            case (route_code[i])
                PORAC_ROUTE_OUT2: next_out2 = next_out2 | route_sig[i];
                PORAC_ROUTE_OUT3: next_out3 = next_out3 | route_sig[i];
                default: next_out2 = next_out2;
            endcase
        end
        next_pd = cfg_pd;
        next_indep = cfg_mode[`PORAC_INDEP_BIT];
        next_trim = cfg_mode[`PORAC_TRIM_LSB +: 3];
        next_trim_khz = 11'(next_trim * `PORAC_OSC_STEP_KHZ);
        case (porac_sel_e'(cfg_sel))
            PORAC_SEL_IN0: sel_pin = pin_filt[0];
            PORAC_SEL_IN1: sel_pin = pin_filt[1];
            PORAC_SEL_IN4: sel_pin = pin_filt[2];
            default: sel_pin = 1'b0;
        endcase
        // secondary only when programmed, selected, pin high
        use_secondary = (cfg_sel != PORAC_SEL_NONE) && (cfg_upper != 4'h0)
                        && sel_pin;
        next_base = use_secondary ? {cfg_upper, 4'h0} : PRIMARY_ADDRESS;
        // low nibble 0..3: bit 0 read, bit 1 upper pages
        next_hit = (bus_addr_byte[7:2] == next_base[7:2]);
        next_is_read = next_hit & bus_addr_byte[0];
        next_page_high = next_hit & bus_addr_byte[1];
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            general_output_2 <= 1'b0;
            general_output_3 <= 1'b0;
            input_zero_pulldown_en <= 1'b0;
            independent_operation <= 1'b0;
            oscillator_trim <= 3'h0;
            oscillator_trim_khz <= 11'h000;
            active_base_address <= 8'h00;
            addr_hit <= 1'b0;
            addr_is_read <= 1'b0;
            addr_page_high <= 1'b0;
        end
        else
        begin
            general_output_2 <= next_out2;
            general_output_3 <= next_out3;
            input_zero_pulldown_en <= next_pd;
            independent_operation <= next_indep;
            oscillator_trim <= next_trim;
            oscillator_trim_khz <= next_trim_khz;
            active_base_address <= next_base;
            addr_hit <= next_hit;
            addr_is_read <= next_is_read;
            addr_page_high <= next_page_high;
        end
    end
endmodule // porac_top

// ===== sim/porac_monitor.sv
`timescale 1ns/1ps
// ========
// register port and address decode checks
module porac_monitor
#(
    parameter logic [7:0] PRIMARY_ADDRESS = 8'hc0
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [8:0] reg_addr,
    input wire porac_pkg::porac_byte_t reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic [7:0] bus_addr_byte,
    input wire logic independent_operation,
    input wire logic [2:0] oscillator_trim,
    input wire logic [10:0] oscillator_trim_khz,
    input wire logic [7:0] active_base_address,
    input wire logic addr_hit,
    input wire logic addr_is_read
);
    import porac_pkg::*;
    logic wr_mode;
    logic wr_alt;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // decoded strobes keep the properties short
    assign wr_mode = reg_wr_en && reg_addr == 9'h147;
    assign wr_alt = reg_wr_en && reg_addr == 9'h148;
    read_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe got no answer");
    read_lone_a: assert property (!reg_rd_en |=> !reg_rd_valid)
        else $error("read answer without strobe");
    rdata_idle_a: assert property (!reg_rd_valid |-> reg_rdata == 8'h00)
        else $error("read data not cleared");
    trim_scale_a: assert property (
        oscillator_trim_khz == 11'(oscillator_trim) * 11'h0b4)
        else $error("trim frequency not code times step");
    trim_write_a: assert property (
        wr_mode |-> ##2 oscillator_trim == $past(reg_wdata[2:0], 2))
        else $error("trim did not follow write");
    mode_write_a: assert property (
        wr_mode |-> ##2 independent_operation == $past(reg_wdata[7], 2))
        else $error("mode bit did not follow write");
    sel_none_a: assert property (
        wr_alt && reg_wdata[1:0] == 2'h0 |->
        ##2 active_base_address == PRIMARY_ADDRESS)
        else $error("secondary base used with no select pin");
    upper_blank_a: assert property (
        wr_alt && reg_wdata[7:4] == 4'h0 |->
        ##2 active_base_address == PRIMARY_ADDRESS)
        else $error("blank upper nibble not treated as default");
    hit_match_a: assert property (
        addr_hit |-> $past(bus_addr_byte[7:2]) == active_base_address[7:2])
        else $error("hit on foreign address");
    read_flag_a: assert property (
        addr_is_read == (addr_hit && $past(bus_addr_byte[0])))
        else $error("read direction flag wrong");
    cover property (wr_mode ##2 independent_operation);
    cover property (addr_hit && addr_is_read);
    cover property (reg_rd_valid && reg_rdata != 8'h00);
    cover property (addr_hit && active_base_address != PRIMARY_ADDRESS);
endmodule // porac_monitor

bind porac_top porac_monitor #(.PRIMARY_ADDRESS(PRIMARY_ADDRESS)) mon (
    .clock(clock), .resetn(resetn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .bus_addr_byte(bus_addr_byte),
    .independent_operation(independent_operation),
    .oscillator_trim(oscillator_trim),
    .oscillator_trim_khz(oscillator_trim_khz),
    .active_base_address(active_base_address), .addr_hit(addr_hit),
    .addr_is_read(addr_is_read));

// ===== sim/porac_host.sv
`timescale 1ns/1ps
// ========
// host side of the register port
module porac_host
(
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [8:0] reg_addr,
    output porac_pkg::porac_byte_t reg_wdata
);
    import porac_pkg::*;
    // idle port at time zero
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse so stale values never pass as new
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // the answer stands only in the cycle after the strobe
    task automatic rd(input logic [8:0] a, output logic [7:0] d,
        output logic v);
        @(negedge clock);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        v = reg_rd_valid;
        d = reg_rdata;
    endtask
endmodule // porac_host

// ===== sim/pmic_output_routing_addr_config_bench.sv
`timescale 1ns/1ps
module pmic_output_routing_addr_config_bench;
    import porac_pkg::*;
    logic clock, resetn, rd_en, wr_en, valid, out2, out3, pd, indep;
    logic hit, is_rd, pg_hi;
    logic [8:0] addr;
    logic [7:0] wdata, rdata, bus_byte, base;
    logic [3:0] ind; // pg b, pg a, ready b, ready a
    logic [2:0] pins; // input 4, 1, 0
    logic [2:0] trim;
    logic [10:0] khz;
    int err_count = 0;
    int checked = 0;
    porac_top dut (.clock(clock), .resetn(resetn), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_rd_valid(valid), .reg_a_power_good(ind[2]),
        .reg_b_power_good(ind[3]), .reg_a_ready(ind[0]),
        .reg_b_ready(ind[1]), .general_input_0(pins[0]),
        .general_input_1(pins[1]), .general_input_4(pins[2]),
        .bus_addr_byte(bus_byte), .general_output_2(out2),
        .general_output_3(out3), .input_zero_pulldown_en(pd),
        .independent_operation(indep), .oscillator_trim(trim),
        .oscillator_trim_khz(khz), .active_base_address(base),
        .addr_hit(hit), .addr_is_read(is_rd), .addr_page_high(pg_hi));
    porac_host host (.clock(clock), .reg_rdata(rdata), .reg_rd_valid(valid),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata));
    // ========
    // checking tasks
    task automatic cmp(input string what, input logic [10:0] exp, got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rd(input logic [8:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        cmp("read valid", 11'h001, 11'(v));
        cmp("read data", 11'(exp), 11'(d));
    endtask
    // pins pass a synchroniser, so the base is polled with a bound
    task automatic wait_base(input logic [7:0] exp);
        for (int n = 0; n < 20 && base !== exp; n++)
            @(negedge clock);
        cmp("base", 11'(exp), 11'(base));
        if (base !== exp)
            wrap_up();
    endtask
    task automatic wrap_up;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ========
    // clock and sequence
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        resetn = 1'b0;
        ind = 4'h0;
        pins = 3'h0;
        bus_byte = 8'h00;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        for (int a = 9'h145; a < 9'h14a; a++)
            chk_rd(9'(a), 8'h00);
        host.wr(9'h145, 8'hff);
        chk_rd(9'h145, 8'h01);
        cmp("pulldown", 11'h001, 11'(pd));
        host.wr(9'h145, 8'h00);
        repeat (2) @(negedge clock);
        cmp("pulldown", 11'h000, 11'(pd));
        for (int f = 0; f < 4; f++)
            for (int c = 0; c < 4; c++)
            begin
                host.wr(9'h146, 8'(c << (2 * f)));
                ind = 4'(1 << f);
                repeat (2) @(negedge clock);
                cmp("out2", 11'(c == 1), 11'(out2));
                cmp("out3", 11'(c == 2), 11'(out3));
                ind = ~ind;
                repeat (2) @(negedge clock);
                cmp("out2 off", 11'h000, 11'({out2, out3}));
            end
        host.wr(9'h146, 8'h50);
        ind = 4'h4;
        chk_rd(9'h146, 8'h50);
        cmp("out2 shared", 11'h001, 11'(out2));
        for (int t = 0; t < 8; t++)
        begin
            host.wr(9'h147, 8'({t[0], 4'ha, 3'(t)}));
            chk_rd(9'h147, 8'({t[0], 4'ha, 3'(t)}));
            cmp("trim", 11'(t), 11'(trim));
            cmp("trim khz", 11'(t * 180), khz);
            cmp("mode", 11'(t[0]), 11'(indep));
        end
        host.wr(9'h148, 8'hff);
        chk_rd(9'h148, 8'hf3);
        // input 4 still low, so the primary base stays in force
        wait_base(8'hc0);
        pins = 3'h4;
        wait_base(8'hf0);
        for (int s = 1; s < 4; s++)
        begin
            // let the low pins pass the filter first, else a stale high
            // pin lets the secondary base flicker on and off
            pins = 3'h0;
            repeat (8) @(negedge clock);
            host.wr(9'h148, 8'(8'hd0 + s));
            wait_base(8'hc0);
            pins = 3'(1 << (s - 1));
            wait_base(8'hd0);
            bus_byte = 8'hd3;
            repeat (2) @(negedge clock);
            cmp("hit", 11'h007, 11'({hit, is_rd, pg_hi}));
            bus_byte = 8'hd0;
            repeat (2) @(negedge clock);
            cmp("hit", 11'h004, 11'({hit, is_rd, pg_hi}));
            bus_byte = 8'hd4;
            repeat (2) @(negedge clock);
            cmp("miss", 11'h000, 11'(hit));
            pins = ~pins;
            wait_base(8'hc0);
        end
        host.wr(9'h148, 8'hd0);
        pins = 3'h7;
        repeat (8) @(negedge clock);
        cmp("base none", 11'h0c0, 11'(base));
        host.wr(9'h148, 8'h01);
        repeat (8) @(negedge clock);
        cmp("base blank", 11'h0c0, 11'(base));
        wrap_up();
    end
endmodule // pmic_output_routing_addr_config_bench
